// File: core/crop_ctrl.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
// register file and selection logic for ladder reference and amplifier
module crop_ctrl import crop_pkg::*; (
  // system
  input wire logic clock_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // analog results and timer
  input wire logic cmp_result_i,
  input wire logic amp_result_i,
  input wire logic timer_two_clock_i,
  input wire logic amp_result_pwm_gate_option_i,
  // analog controls
  output logic [1:0] ref_range_o,
  output logic [3:0] ref_level_o,
  output logic [5:0] ref_tap_o,
  output logic amp_enable_o,
  output logic [2:0] amp_minus_sel_o,
  output logic [1:0] amp_plus_sel_o,
  output logic [3:0] amp_offset_o,
  // pin and system
  output logic pa0_cmp_out_en_o,
  output logic pa0_amp_takeover_o,
  output logic amp_result_o,
  output logic amp_timer_count_o,
  output logic amp_pwm_gate_o,
  output logic wake_o,
  output logic irq_o
);
  typedef struct packed {
    logic [7:0] ref_sel;
    logic [7:0] amp_ctl;
    logic [3:0] trim;
    logic [IRQ_BITS-1:0] status;
    logic [IRQ_BITS-1:0] enable;
    logic [7:0] rdata;
    logic held;
    logic wake;
    logic irq;
    logic [5:0] tap;
    // registered pin and result outputs
    logic amp_res;
    logic cmp_pin;
    logic pwm_gate;
  } crop_ctrl_t;
  crop_ctrl_t st;
  crop_ctrl_t next_st;
  crop_sync_if cmp_s();
  crop_sync_if amp_s();
  crop_sync_if tm_s();
  logic [5:0] tap;
  logic amp_out;
  logic tm_rise;
  logic [IRQ_BITS-1:0] events;
  logic [IRQ_BITS-1:0] clr;

  crop_edge u_cmp (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .level_i(cmp_s.level),
    .stable_o(cmp_s.stable),
    .changed_o(cmp_s.changed)
  );
  crop_edge u_amp (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .level_i(amp_s.level),
    .stable_o(amp_s.stable),
    .changed_o(amp_s.changed)
  );
  crop_edge u_tm (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .level_i(tm_s.level),
    .stable_o(tm_s.stable),
    .changed_o(tm_s.changed)
  );
  crop_tap u_tap (
    .range_i(st.ref_sel[BIT_REF_HIGH:BIT_REF_LOW]),
    .level_i(st.ref_sel[3:0]),
    .tap_o(tap)
  );
  assign cmp_s.level = cmp_result_i;
  assign amp_s.level = amp_result_i;
  assign tm_s.level = timer_two_clock_i;

  // timer rising edge and result path choice
  always_comb begin
    tm_rise = tm_s.changed & tm_s.stable;
    amp_out = st.amp_ctl[BIT_AMP_SAMPLE] ? st.held : amp_s.stable;
  end

  // event sources and clear word
  always_comb begin
    events = '0;
    events[IRQ_WAKE] = st.ref_sel[BIT_REF_WAKE] & cmp_s.changed;
    events[IRQ_AMP_EDGE] = st.amp_ctl[BIT_AMP_EN] & amp_s.changed;
    clr = (wr_i && addr_i == ADDR_IRQ_CLEAR) ? wdata_i[IRQ_BITS-1:0] : '0;
  end

  // register writes, reads and derived outputs
  always_comb begin
    next_st = st;
    if (wr_i) begin
      case (addr_i)
        ADDR_REF_SELECT: next_st.ref_sel = wdata_i;
        ADDR_AMP_CONTROL: begin
          next_st.amp_ctl[7] = wdata_i[7];
          next_st.amp_ctl[5:0] = wdata_i[5:0];
        end
        ADDR_OFFSET_TRIM: next_st.trim = wdata_i[3:0];
        ADDR_IRQ_ENABLE: next_st.enable = wdata_i[IRQ_BITS-1:0];
        default: next_st.ref_sel = st.ref_sel;
      endcase
    end
    // set wins over clear
    next_st.status = (st.status & ~clr) | events;
    // hold on timer edge
    if (tm_rise) begin
      next_st.held = amp_s.stable;
    end
    next_st.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        ADDR_AMP_CONTROL: next_st.rdata = {st.amp_ctl[7], amp_s.stable, st.amp_ctl[5:0]};
        ADDR_OFFSET_TRIM: next_st.rdata = {4'h0, st.trim};
        ADDR_IRQ_STATUS: next_st.rdata = {6'h00, st.status};
        ADDR_IRQ_ENABLE: next_st.rdata = {6'h00, st.enable};
        default: next_st.rdata = 8'h00; // write-only and unmapped read zero
      endcase
    end
    next_st.wake = events[IRQ_WAKE];
    next_st.irq = |(next_st.status & next_st.enable);
    next_st.tap = tap;
    // pin ownership and result outputs come straight from flops
    next_st.amp_res = amp_out;
    next_st.cmp_pin = next_st.ref_sel[BIT_REF_PIN] & ~next_st.amp_ctl[BIT_AMP_EN];
    next_st.pwm_gate = amp_out & amp_result_pwm_gate_option_i;
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // output registers (amp result drives timers and pwm)
  assign rdata_o = st.rdata;
  assign ref_range_o = st.ref_sel[5:4];
  assign ref_level_o = st.ref_sel[3:0];
  assign ref_tap_o = st.tap;
  assign amp_enable_o = st.amp_ctl[BIT_AMP_EN];
  assign amp_minus_sel_o = st.amp_ctl[4:2];
  assign amp_plus_sel_o = st.amp_ctl[1:0];
  assign amp_offset_o = st.trim;

  // pin ownership: comparator output is kept off the pin while the amp owns it
  assign pa0_cmp_out_en_o = st.cmp_pin;
  assign pa0_amp_takeover_o = st.amp_ctl[BIT_AMP_EN];
  assign amp_result_o = st.amp_res;
  assign amp_timer_count_o = st.amp_res;
  assign amp_pwm_gate_o = st.pwm_gate;
  assign wake_o = st.wake;
  assign irq_o = st.irq;

  // checks
  property p_wake;
    @(posedge clock_i) disable iff (!rst_b_i)
      (st.ref_sel[BIT_REF_WAKE] && cmp_s.changed) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing");
  property p_nowake;
    @(posedge clock_i) disable iff (!rst_b_i)
      !st.ref_sel[BIT_REF_WAKE] |=> !wake_o;
  endproperty
  a_nowake: assert property (p_nowake) else $error("spurious wake");
  property p_take;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_AMP_CONTROL && wdata_i[7]) |=> pa0_amp_takeover_o;
  endproperty
  a_take: assert property (p_take) else $error("no takeover");
  property p_tap;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_REF_SELECT) |=> ##1 ref_tap_o == $past(wdata_i[5:0], 2);
  endproperty
  a_tap: assert property (p_tap) else $error("tap wrong");
  property p_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      (st.amp_ctl[BIT_AMP_SAMPLE] && !tm_rise && $stable(st.amp_ctl)) |=> $stable(st.held);
  endproperty
  a_hold: assert property (p_hold) else $error("held moved");
  property p_rd;
    @(posedge clock_i) disable iff (!rst_b_i)
      (rd_i && addr_i == ADDR_AMP_CONTROL) |=> rdata_o[6] == $past(amp_s.stable);
  endproperty
  a_rd: assert property (p_rd) else $error("result bit wrong");
  property p_trim;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_OFFSET_TRIM) |=> amp_offset_o == $past(wdata_i[3:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim wrong");
  property p_pin;
    @(posedge clock_i) disable iff (!rst_b_i)
      pa0_amp_takeover_o |-> !pa0_cmp_out_en_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pa0 fight");

  // range bits land one cycle after the write
  property p_range;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_REF_SELECT)
      |=> ref_range_o == $past(wdata_i[BIT_REF_HIGH:BIT_REF_LOW]);
  endproperty
  a_range: assert property (p_range) else $error("range wrong");

  // level field lands one cycle after the write
  property p_level;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_REF_SELECT)
      |=> ref_level_o == $past(wdata_i[3:0]);
  endproperty
  a_level: assert property (p_level) else $error("level wrong");

  // reference select is write-only and reads back zero
  property p_ref_wo;
    @(posedge clock_i) disable iff (!rst_b_i)
      (rd_i && addr_i == ADDR_REF_SELECT)
      |=> rdata_o == 8'h00;
  endproperty
  a_ref_wo: assert property (p_ref_wo) else $error("ref readable");

  // pin output follows the enable bit while the amp is off
  property p_pin_on;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_REF_SELECT && wdata_i[BIT_REF_PIN] && !amp_enable_o)
      |=> pa0_cmp_out_en_o;
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin output missing");

  // clearing the enable bit takes the comparator off the pin
  property p_pin_off;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_REF_SELECT && !wdata_i[BIT_REF_PIN])
      |=> !pa0_cmp_out_en_o;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin output stuck");

  // disabling the amp hands the pin back
  property p_release;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_AMP_CONTROL && !wdata_i[BIT_AMP_EN])
      |=> !pa0_amp_takeover_o && !amp_enable_o;
  endproperty
  a_release: assert property (p_release) else $error("pin not released");

  // minus input select lands one cycle after the write
  property p_minus;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_AMP_CONTROL)
      |=> amp_minus_sel_o == $past(wdata_i[4:2]);
  endproperty
  a_minus: assert property (p_minus) else $error("minus select wrong");

  // plus input select lands one cycle after the write
  property p_plus;
    @(posedge clock_i) disable iff (!rst_b_i)
      (wr_i && addr_i == ADDR_AMP_CONTROL)
      |=> amp_plus_sel_o == $past(wdata_i[1:0]);
  endproperty
  a_plus: assert property (p_plus) else $error("plus select wrong");

  // direct mode passes the synchronised result through
  property p_direct;
    @(posedge clock_i) disable iff (!rst_b_i)
      !st.amp_ctl[BIT_AMP_SAMPLE]
      |=> amp_result_o == $past(amp_s.stable);
  endproperty
  a_direct: assert property (p_direct) else $error("direct result wrong");

  // sampled mode shows only the held value
  property p_sampled;
    @(posedge clock_i) disable iff (!rst_b_i)
      st.amp_ctl[BIT_AMP_SAMPLE]
      |=> amp_result_o == $past(st.held);
  endproperty
  a_sampled: assert property (p_sampled) else $error("sampled result wrong");

  // timer rising edge loads the held value
  property p_load;
    @(posedge clock_i) disable iff (!rst_b_i)
      tm_rise
      |=> st.held == $past(amp_s.stable);
  endproperty
  a_load: assert property (p_load) else $error("held not loaded");

  // pwm gate stays low without the option
  property p_pwm_off;
    @(posedge clock_i) disable iff (!rst_b_i)
      !amp_result_pwm_gate_option_i
      |=> !amp_pwm_gate_o;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm gate leaks");

  // pwm gate follows the result with the option
  property p_pwm_on;
    @(posedge clock_i) disable iff (!rst_b_i)
      amp_result_pwm_gate_option_i
      |=> amp_pwm_gate_o == amp_result_o;
  endproperty
  a_pwm_on: assert property (p_pwm_on) else $error("pwm gate wrong");

  // an enabled wake event raises the interrupt
  property p_irq;
    @(posedge clock_i) disable iff (!rst_b_i)
      (events[IRQ_WAKE] && st.enable[IRQ_WAKE] && !(wr_i && addr_i == ADDR_IRQ_ENABLE))
      |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  // no comparator change, no wake
  property p_quiet;
    @(posedge clock_i) disable iff (!rst_b_i)
      !cmp_s.changed
      |=> !wake_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("wake without change");

  // main scenarios reached
  c_wake: cover property (@(posedge clock_i) disable iff (!rst_b_i) wake_o);
  c_irq: cover property (@(posedge clock_i) disable iff (!rst_b_i) irq_o);
  c_samp: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    st.amp_ctl[BIT_AMP_SAMPLE] && tm_rise);
  c_take: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    pa0_amp_takeover_o && amp_result_o);
  c_pwm: cover property (@(posedge clock_i) disable iff (!rst_b_i) amp_pwm_gate_o);
endmodule

// File: common/crop_pkg.sv
// Behaviour
// - comparator level change wakes when enabled
// - range bits five and four pick ladder
// - four-bit level selects ladder tap
// - sixteen equal steps per range
// - reference bit seven routes comparator to pin
// - amp enable bit seven takes pin
// - amp bit six reads comparison result
// - amp bit five selects timer sampling
// - amp bits four-two select minus input
// - amp bits one-zero select plus input
// - offset trim four-bit code, signed steps
// - amp result counts timer two/three
// - amp result gates pwm when optioned
package crop_pkg;
  localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h07;
  localparam logic [7:0] ADDR_AMP_CONTROL = 8'h1A;
  localparam logic [7:0] ADDR_REF_SELECT = 8'h19;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h41;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h42;
  localparam int BIT_REF_PIN = 7;
  localparam int BIT_REF_WAKE = 6;
  localparam int BIT_REF_HIGH = 5;
  localparam int BIT_REF_LOW = 4;
  localparam int BIT_AMP_EN = 7;
  localparam int BIT_AMP_RESULT = 6;
  localparam int BIT_AMP_SAMPLE = 5;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [2:0] MINUS_PA3 = 3'h0;
  localparam logic [2:0] MINUS_PA4 = 3'h1;
  localparam logic [2:0] MINUS_BANDGAP = 3'h2;
  localparam logic [2:0] MINUS_LADDER = 3'h3;
  localparam logic [2:0] MINUS_PB6 = 3'h4;
  localparam logic [1:0] PLUS_PA4 = 2'h0;
  localparam logic [1:0] PLUS_GND = 2'h1;
  localparam logic [1:0] PLUS_LADDER = 2'h2;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_AMP_EDGE = 1;
  localparam int IRQ_BITS = 2;
endpackage

// File: common/crop_sync_if.sv
`timescale 1ns/1ps
interface crop_sync_if;
  logic level;
  logic stable;
  logic changed;
  modport src(input level);
  modport dst(output stable, output changed);
endinterface

// File: core/crop_edge.sv
`timescale 1ns/1ps
// two-stage synchroniser plus change detector on the second stage
module crop_edge import crop_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic level_i,
  output logic stable_o,
  output logic changed_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } crop_edge_t;
  crop_edge_t st;
  crop_edge_t next_st;
  // shift through the stages
  always_comb begin
    next_st = st;
    next_st.s1 = level_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign stable_o = st.s2;
  assign changed_o = st.s2 ^ st.s3;
endmodule

// File: core/crop_tap.sv
`timescale 1ns/1ps
// ladder tap index: range bits above level field, one of 64 taps
module crop_tap import crop_pkg::*; (
  input wire logic [1:0] range_i,
  input wire logic [3:0] level_i,
  output logic [5:0] tap_o
);
  // sixteen equal steps within each range
  assign tap_o = {range_i, level_i};
endmodule

// File: verif/crop_ctrl_tb_top.sv
`timescale 1ns/1ps
module crop_ctrl_tb_top import crop_pkg::*; ;
  // design stimulus and observed outputs
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic cmp_result_i = 1'b0;
  logic amp_result_i = 1'b0;
  logic timer_two_clock_i = 1'b0;
  logic amp_result_pwm_gate_option_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic [7:0] d;
  logic [7:0] v;
  logic [1:0] ref_range_o;
  logic [1:0] amp_plus_sel_o;
  logic [3:0] ref_level_o;
  logic [3:0] amp_offset_o;
  logic [5:0] ref_tap_o;
  logic [2:0] amp_minus_sel_o;
  logic amp_enable_o, pa0_cmp_out_en_o, pa0_amp_takeover_o, amp_result_o;
  logic amp_timer_count_o, amp_pwm_gate_o, wake_o, irq_o;
  int failures = 0;
  int n_tests = 0;
  int i;
  int n;

  crop_ctrl DUT (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .cmp_result_i(cmp_result_i),
    .amp_result_i(amp_result_i),
    .timer_two_clock_i(timer_two_clock_i),
    .amp_result_pwm_gate_option_i(amp_result_pwm_gate_option_i),
    .ref_range_o(ref_range_o),
    .ref_level_o(ref_level_o),
    .ref_tap_o(ref_tap_o),
    .amp_enable_o(amp_enable_o),
    .amp_minus_sel_o(amp_minus_sel_o),
    .amp_plus_sel_o(amp_plus_sel_o),
    .amp_offset_o(amp_offset_o),
    .pa0_cmp_out_en_o(pa0_cmp_out_en_o),
    .pa0_amp_takeover_o(pa0_amp_takeover_o),
    .amp_result_o(amp_result_o),
    .amp_timer_count_o(amp_timer_count_o),
    .amp_pwm_gate_o(amp_pwm_gate_o),
    .wake_o(wake_o),
    .irq_o(irq_o)
  );

  // 50 MHz system clock
  always #10 clock_i = ~clock_i;

  // compare one value and count it
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one-cycle register write, settled just after the taking edge
  task automatic wr(logic [7:0] a, logic [7:0] w);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= w;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic rd(logic [7:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic cyc(int c);
    repeat (c) @(posedge clock_i);
    #1;
  endtask

  // count wake pulses over a fixed window after a comparator toggle
  task automatic wake_count();
    @(posedge clock_i);
    cmp_result_i <= ~cmp_result_i;
    n = 0;
    for (i = 0; i < 6; i++) begin
      cyc(1);
      if (wake_o === 1'b1) n++;
    end
  endtask

  task automatic t_reset();
    chk("outs", {amp_enable_o, pa0_cmp_out_en_o, pa0_amp_takeover_o, wake_o, irq_o}, 8'h00);
    rd(ADDR_AMP_CONTROL);
    chk("amp ctl", d, 8'h00);
    rd(ADDR_OFFSET_TRIM);
    chk("trim", d, 8'h00);
    rd(8'hFF);
    chk("unmapped", d, 8'h00);
    $display("done reset");
  endtask

  task automatic t_amp();
    for (int k = 0; k < 5; k++) begin
      v = 8'h80 | 8'(k * 4 + k % 3);
      wr(ADDR_AMP_CONTROL, v | 8'h40);
      chk("minus", 8'(amp_minus_sel_o), 8'(k));
      chk("plus", 8'(amp_plus_sel_o), 8'(k % 3));
      chk("take", {amp_enable_o, pa0_amp_takeover_o}, 8'h03);
      rd(ADDR_AMP_CONTROL);
      chk("amp rb", d, v);
    end
    wr(ADDR_AMP_CONTROL, 8'h00);
    chk("release", {amp_enable_o, pa0_amp_takeover_o}, 8'h00);
    $display("done amp");
  endtask

  task automatic t_ref();
    for (int k = 0; k < 4; k++) begin
      v = {2'b10, 2'(k), 4'(k * 5)};
      wr(ADDR_REF_SELECT, v);
      chk("range", 8'(ref_range_o), 8'(k));
      chk("level", 8'(ref_level_o), 8'(k * 5));
      chk("pin", 8'(pa0_cmp_out_en_o), 8'h01);
      cyc(1);
      chk("tap", 8'(ref_tap_o), 8'(v[5:0]));
    end
    rd(ADDR_REF_SELECT);
    chk("ref wo", d, 8'h00);
    wr(ADDR_AMP_CONTROL, 8'h80);
    chk("pin off", 8'(pa0_cmp_out_en_o), 8'h00);
    wr(ADDR_AMP_CONTROL, 8'h00);
    $display("done ref");
  endtask

  task automatic t_trim();
    for (int k = 0; k < 16; k += 7) begin
      wr(ADDR_OFFSET_TRIM, 8'(k));
      chk("offset", 8'(amp_offset_o), 8'(k));
      rd(ADDR_OFFSET_TRIM);
      chk("trim rb", 8'(d[3:0]), 8'(k));
    end
    $display("done trim");
  endtask

  task automatic t_result();
    wr(ADDR_AMP_CONTROL, 8'h80); // pin is the amp's, its digital input stays off
    @(posedge clock_i);
    amp_result_i <= 1'b1;
    cyc(5);
    chk("direct", {amp_result_o, amp_timer_count_o, amp_pwm_gate_o}, 8'h06);
    @(posedge clock_i);
    amp_result_pwm_gate_option_i <= 1'b1;
    cyc(1);
    chk("pwm", 8'(amp_pwm_gate_o), 8'h01);
    rd(ADDR_AMP_CONTROL); // result read back in direct mode
    chk("res bit", 8'(d[6]), 8'h01);
    // one timer edge while the result is high loads the held value
    @(posedge clock_i);
    timer_two_clock_i <= 1'b1;
    cyc(4);
    @(posedge clock_i);
    timer_two_clock_i <= 1'b0;
    cyc(3);
    wr(ADDR_AMP_CONTROL, 8'hA0);
    @(posedge clock_i);
    amp_result_i <= 1'b0;
    cyc(8);
    chk("held", 8'(amp_result_o), 8'h01);
    @(posedge clock_i);
    timer_two_clock_i <= 1'b1;
    cyc(5);
    chk("sampled", {amp_result_o, amp_pwm_gate_o}, 8'h00);
    @(posedge clock_i);
    timer_two_clock_i <= 1'b0;
    wr(ADDR_AMP_CONTROL, 8'h00);
    $display("done result");
  endtask

  task automatic t_wake();
    wr(ADDR_IRQ_CLEAR, 8'h03);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    wr(ADDR_REF_SELECT, 8'h40);
    wake_count();
    chk("wake", 8'(n), 8'h01);
    chk("irq", 8'(irq_o), 8'h01);
    rd(ADDR_IRQ_STATUS);
    chk("status", d, 8'h01);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    cyc(1);
    chk("masked", 8'(irq_o), 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    wr(ADDR_IRQ_CLEAR, 8'h01);
    cyc(1);
    chk("cleared", 8'(irq_o), 8'h00);
    rd(ADDR_IRQ_STATUS);
    chk("status clr", d, 8'h00);
    wr(ADDR_REF_SELECT, 8'h00);
    wake_count();
    chk("no wake", 8'(n), 8'h00);
    $display("done wake");
  endtask

  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    cyc(1);
    t_reset();
    t_amp();
    t_ref();
    t_trim();
    t_result();
    t_wake();
    finish_test();
  end
endmodule
